// ---- logic/port_pin_state_map.vh ----
// Register offsets, reset values and timer field codes for the eight-bit port.
`ifndef PORT_PIN_STATE_MAP_VH
`define PORT_PIN_STATE_MAP_VH

// ==========================================================================
// Register offsets (lower 16 bits of the address)
`define PORT_DIRECTION_OFFS    16'hFEB0
`define PORT_PIN_STATE_OFFS    16'hFF50
`define PORT_OUTPUT_DATA_OFFS  16'hFF60

// ==========================================================================
// Reset values and fixed read answers
`define PORT_DIRECTION_RST     8'h00
`define PORT_OUTPUT_DATA_RST   8'h00
`define PORT_DIRECTION_RDVAL   8'hFF
`define PORT_UNMAPPED_RDVAL    8'h00
`define PORT_READ_IDLE         8'h00

// ==========================================================================
// Pin seven and field positions
`define PIN7_BIT               7
`define IO_B_CAPTURE_BIT       3
`define IO_B_EDGE_HI           1
`define IO_B_EDGE_LO           0

// ==========================================================================
// Timer field codes
`define MODE_NORMAL            4'h0
`define MODE_GROUP_HI          3
`define MODE_GROUP_LO          2
`define MODE_GROUP_CODE        2'h1
`define MODE_PWM1              4'h2
`define MODE_PWM2              4'h3
`define IO_B_NO_EDGE           2'h0
`define CLEAR_BY_B             2'h2
`define PRESCALE_EXT_D         3'h7

`endif

// ---- logic/pin_sync.v ----
// Three-stage synchroniser with agreement filter for asynchronous pin levels.
module pin_sync #(
	parameter WIDTH = 8
) (
	// Clock, reset and enable
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             clk_en,
	// Asynchronous levels in, filtered levels out
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] level_r
);

	reg [WIDTH-1:0] stage1_r;
	reg [WIDTH-1:0] stage2_r;
	reg [WIDTH-1:0] stage3_r;
	integer         i;

	// ======================================================================
	// Synchroniser chain
	// Only the second stage reads the first; the filter looks at stages two
	// and three so that a metastable first stage never reaches software.
	always @(posedge sys_clk) begin
		if (rst) begin
			stage1_r <= {WIDTH{1'b0}};
			stage2_r <= {WIDTH{1'b0}};
			stage3_r <= {WIDTH{1'b0}};
			level_r  <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (stage2_r[i] == stage3_r[i]) begin
					level_r[i] <= stage3_r[i];
				end
			end
		end
	end

endmodule // pin_sync

// ---- logic/port_pin_state_gpio.v ----
// Eight-bit general purpose port with pin seven shared by timer and pulse units.
//
// What this block does
// - Pin functions identical in every operating mode.
// - Direction bit 1 output, 0 input.
// - Direction register write-only; reads return 8'hFF.
// - Direction cleared by power-on, hardware standby.
// - Output data register eight-bit read/write.
// - Output data cleared by power-on, hardware standby.
// - Pin-state register read-only, writes ignored.
// - Pin-state read mixes output data and pins.
// - Pin-state held through manual reset, software standby.
// - Manual reset leaves pins to direction, data.
// - Timer output B owns pin seven first.
// - Otherwise input, general output or pulse output.
// - Capture input B on mode and field.
// - External clock D by prescaler code 111.
// - External clock D when channels 2 and 4 both phase count.
// - Compare output codes in normal modes.
// - PWM mode 2 output unless cleared by B.
`include "port_pin_state_map.vh"

module port_pin_state_gpio #(
	parameter WIDTH = 8
) (
	// Clock, power-on reset and clock enable
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             clk_en,
	// Power state controls
	input  wire             manual_rst,
	input  wire             hw_standby,
	input  wire             sw_standby,
	// Register port
	input  wire [15:0]      addr,
	input  wire [WIDTH-1:0] wdata,
	input  wire             wr,
	input  wire             rd,
	output reg  [WIDTH-1:0] rdata,
	// Timer channel 2 settings and output level
	input  wire [3:0]       timer_mode_field,
	input  wire [3:0]       io_control_b_field,
	input  wire [1:0]       counter_clear_field,
	input  wire             timer2_out_b,
	// Prescaler settings of channels 0 and 5, phase counting of 2 and 4
	input  wire [2:0]       prescaler_select_ch0,
	input  wire [2:0]       prescaler_select_ch5,
	input  wire             ch2_phase_count,
	input  wire             ch4_phase_count,
	// Pulse output 15
	input  wire             pulse_out15_enable,
	input  wire             pulse_output_15,
	// Pins
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_out,
	output reg  [WIDTH-1:0] pin_oe,
	// Pin seven towards the timer
	output reg              timer2_io_b,
	output reg              timer2_capture_en,
	output reg              ext_clock_d,
	output reg              ext_clock_d_en
);

	// ======================================================================
	// Decode helpers

	// True for timer mode 0000 or 01xx.
	function normal_mode;
		input [3:0] mode;
		begin
			normal_mode = (mode == `MODE_NORMAL) ||
				(mode[`MODE_GROUP_HI:`MODE_GROUP_LO] == `MODE_GROUP_CODE);
		end
	endfunction

	// True for an access strobe that hits the given offset.
	function hit;
		input        strobe;
		input [15:0] a;
		input [15:0] offs;
		begin
			hit = strobe && (a == offs);
		end
	endfunction

	// True when the edge bits of an I/O control field ask for an output.
	function edge_code_set;
		input [3:0] code;
		begin
			edge_code_set = (code[`IO_B_EDGE_HI:`IO_B_EDGE_LO] != `IO_B_NO_EDGE);
		end
	endfunction

	// True for a prescaler code that selects external clock D.
	function prescale_ext;
		input [2:0] code;
		begin
			prescale_ext = (code == `PRESCALE_EXT_D);
		end
	endfunction

	// ======================================================================
	// State
	reg  [WIDTH-1:0] port_direction_r;
	reg  [WIDTH-1:0] port_direction_nxt;
	reg  [WIDTH-1:0] port_output_data_r;
	reg  [WIDTH-1:0] port_output_data_nxt;
	reg  [WIDTH-1:0] port_pin_state_r;
	reg  [WIDTH-1:0] port_pin_state_nxt;
	reg  [WIDTH-1:0] rdata_nxt;
	reg  [WIDTH-1:0] pin_out_nxt;
	reg  [WIDTH-1:0] pin_oe_nxt;
	reg              units_held_r;
	wire [WIDTH-1:0] pin_level;
	wire             clear_regs;
	reg              timer_drives;
	reg              compare_sel;
	reg              pwm2_sel;
	reg              units_idle;
	reg              capture_sel;
	reg              ext_clk_sel;
	reg              pulse_drives;
	wire             dir_wr_hit;
	wire             data_wr_hit;

	// Power-on reset and hardware standby share one clear path.
	assign clear_regs = rst || hw_standby;

	// Write decode for the two writable registers.
	assign dir_wr_hit  = hit(wr, addr, `PORT_DIRECTION_OFFS);
	assign data_wr_hit = hit(wr, addr, `PORT_OUTPUT_DATA_OFFS);

	// ======================================================================
	// Pin synchroniser
	// pins synchronised first
	pin_sync #(
		.WIDTH    (WIDTH)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.clk_en   (clk_en),
		.async_in (pin_in),
		.level_r  (pin_level)
	);

	// ======================================================================
	// Register write path
	always @* begin
		port_direction_nxt   = port_direction_r;
		port_output_data_nxt = port_output_data_r;
		if (dir_wr_hit) begin
			port_direction_nxt = wdata;
		end
		if (data_wr_hit) begin
			port_output_data_nxt = wdata;
		end
	end

	always @(posedge sys_clk) begin
		if (clear_regs) begin
			port_direction_r   <= `PORT_DIRECTION_RST;
			port_output_data_r <= `PORT_OUTPUT_DATA_RST;
		end else if (clk_en) begin
			// Manual reset and software standby leave both registers alone.
			port_direction_r   <= port_direction_nxt;
			port_output_data_r <= port_output_data_nxt;
		end
	end

	// ======================================================================
	// Pin-state capture
	always @* begin
		port_pin_state_nxt = (port_direction_r & port_output_data_r) |
			(~port_direction_r & pin_level);
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			port_pin_state_r <= `PORT_OUTPUT_DATA_RST;
		end else if (clk_en) begin
			// held in manual reset, software standby
			if (!(manual_rst || sw_standby) || hw_standby) begin
				port_pin_state_r <= port_pin_state_nxt;
			end
		end
	end

	// ======================================================================
	// Register read path
	// Read data stand for exactly the cycle after the strobe and are idle
	// otherwise, so a stale value can never be mistaken for an answer.
	always @* begin
		rdata_nxt = `PORT_READ_IDLE;
		if (rd) begin
			case (addr)
				`PORT_DIRECTION_OFFS:   rdata_nxt = `PORT_DIRECTION_RDVAL;
				`PORT_OUTPUT_DATA_OFFS: rdata_nxt = port_output_data_r;
				`PORT_PIN_STATE_OFFS:   rdata_nxt = port_pin_state_r;
				default:                rdata_nxt = `PORT_UNMAPPED_RDVAL;
			endcase
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			rdata <= `PORT_READ_IDLE;
		end else if (clk_en) begin
			rdata <= rdata_nxt;
		end
	end

	// ======================================================================
	// Manual reset hold of the timer and pulse units
	// The timer and pulse units are reset by a manual reset; their settings for
	// pin seven drive are taken as idle through the first cycle after it ends.
	always @(posedge sys_clk) begin
		if (rst) begin
			units_held_r <= 1'b0;
		end else if (clk_en) begin
			units_held_r <= manual_rst;
		end
	end

	// ======================================================================
	// Pin seven function decode
	// no operating mode input
	// The decode looks only at timer, pulse and direction settings, so the
	// same pin assignment holds whatever mode the chip was started in.

	always @* begin
		compare_sel = 1'b0;
		if (normal_mode(timer_mode_field)) begin
			compare_sel = !io_control_b_field[`IO_B_CAPTURE_BIT] &&
				edge_code_set(io_control_b_field);
		end
	end

	always @* begin
		pwm2_sel = 1'b0;
		if (timer_mode_field == `MODE_PWM2) begin
			pwm2_sel = edge_code_set(io_control_b_field) &&
				(counter_clear_field != `CLEAR_BY_B);
		end
		// Mode 0010 and all other modes except the normal ones and PWM mode 2 (0011) leave the pin to the port.
	end

	// manual reset idles units
	// The extra cycle covers the first edge after release, when the units
	// have only just left their own reset.
	always @* begin
		units_idle = manual_rst || units_held_r;
	end

	always @* begin
		timer_drives = 1'b0;
		if (!units_idle) begin
			timer_drives = compare_sel || pwm2_sel;
		end
	end

	always @* begin
		capture_sel = normal_mode(timer_mode_field) &&
			io_control_b_field[`IO_B_CAPTURE_BIT];
	end

	always @* begin
		ext_clk_sel = prescale_ext(prescaler_select_ch0) ||
			prescale_ext(prescaler_select_ch5);
		if (ch2_phase_count && ch4_phase_count) begin
			ext_clk_sel = 1'b1;
		end
	end

	always @* begin
		pulse_drives = pulse_out15_enable && !units_idle;
	end

	// ======================================================================
	// Pin drive
	// Outputs are registered, so a written register reaches the pins one
	// cycle after it is stored; the trade buys glitch-free pin drive.
	always @* begin
		pin_oe_nxt  = port_direction_r;
		pin_out_nxt = port_output_data_r;
		if (timer_drives) begin
			pin_oe_nxt[`PIN7_BIT]  = 1'b1;
			pin_out_nxt[`PIN7_BIT] = timer2_out_b;
		end else if (port_direction_r[`PIN7_BIT] && pulse_drives) begin
			pin_out_nxt[`PIN7_BIT] = pulse_output_15;
		end
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			pin_out <= `PORT_OUTPUT_DATA_RST;
			pin_oe  <= `PORT_DIRECTION_RST;
		end else if (clk_en) begin
			pin_out <= pin_out_nxt;
			pin_oe  <= pin_oe_nxt;
		end
	end

	// ======================================================================
	// Pin seven towards the timer
	// Both inputs carry the same filtered level; the enables tell the timer
	// whether to use it, so edges seen while unselected do no harm.
	always @(posedge sys_clk) begin
		if (rst) begin
			timer2_io_b       <= 1'b0;
			timer2_capture_en <= 1'b0;
			ext_clock_d       <= 1'b0;
			ext_clock_d_en    <= 1'b0;
		end else if (clk_en) begin
			timer2_io_b       <= pin_level[`PIN7_BIT];
			timer2_capture_en <= capture_sel;
			ext_clock_d       <= pin_level[`PIN7_BIT];
			ext_clock_d_en    <= ext_clk_sel;
		end
	end

endmodule // port_pin_state_gpio

// ---- test/port_pin_state_gpio_sva.sv ----
// Concurrent checks on the eight-bit port and the sharing of pin seven.
module port_pin_state_gpio_sva #(
	parameter WIDTH = 8
) (
	// Clock and resets
	input wire             sys_clk,
	input wire             rst,
	input wire             manual_rst,
	input wire             hw_standby,
	// Register port
	input wire [15:0]      addr,
	input wire [WIDTH-1:0] wdata,
	input wire             wr,
	input wire             rd,
	input wire [WIDTH-1:0] rdata,
	// Timer settings
	input wire [3:0]       timer_mode_field,
	input wire [3:0]       io_control_b_field,
	input wire [1:0]       counter_clear_field,
	input wire             timer2_out_b,
	input wire [2:0]       prescaler_select_ch0,
	input wire [2:0]       prescaler_select_ch5,
	input wire             ch2_phase_count,
	input wire             ch4_phase_count,
	// Pin side
	input wire [WIDTH-1:0] pin_out,
	input wire [WIDTH-1:0] pin_oe,
	input wire             timer2_capture_en,
	input wire             ext_clock_d_en
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ==========================================================================
	// Shadow copies of the writable registers
	reg [WIDTH-1:0] dir_r;
	reg [WIDTH-1:0] data_r;
	always @(posedge sys_clk) begin
		if (rst || hw_standby) begin
			dir_r  <= 8'h00;
			data_r <= 8'h00;
		end else if (wr) begin
			if (addr == 16'hFEB0) dir_r <= wdata;
			if (addr == 16'hFF60) data_r <= wdata;
		end
	end
	wire norm   = timer_mode_field == 4'h0 || timer_mode_field[3:2] == 2'h1;
	wire drive7 = io_control_b_field[1:0] != 2'h0 && (norm && !io_control_b_field[3] ||
		timer_mode_field == 4'h3 && counter_clear_field != 2'h2);
	// ==========================================================================
	// Assertions
	dir_read_a: assert property (rd && addr == 16'hFEB0 |=> rdata == 8'hFF)
		else $error("direction read did not return the fixed value");
	read_idle_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not idle");
	data_read_a: assert property (rd && addr == 16'hFF60 |=> rdata == $past(data_r))
		else $error("output data read back wrong");
	pin_dir_a: assert property (pin_oe[6:0] == $past(dir_r[6:0]) && pin_out[6:0] == $past(data_r[6:0]))
		else $error("general pins do not follow registers");
	timer_own_a: assert property (drive7 && !manual_rst && !$past(manual_rst) |=>
		pin_oe[7] && pin_out[7] == $past(timer2_out_b)) else $error("timer does not own pin seven");
	no_timer_a: assert property (!drive7 |=> pin_oe[7] == $past(dir_r[7]))
		else $error("pin seven enable not from direction");
	manual_pin_a: assert property (manual_rst |=> pin_oe[7] == $past(dir_r[7]) &&
		pin_out[7] == $past(data_r[7])) else $error("override active in manual reset");
	capture_sel_a: assert property (1'b1 |=>
		timer2_capture_en == $past(norm && io_control_b_field[3])) else $error("capture select wrong");
	ext_clock_a: assert property (1'b1 |=> ext_clock_d_en == $past(prescaler_select_ch0 == 3'h7 ||
		prescaler_select_ch5 == 3'h7 || ch2_phase_count && ch4_phase_count))
		else $error("external clock select wrong");
endmodule // port_pin_state_gpio_sva

bind port_pin_state_gpio port_pin_state_gpio_sva #(.WIDTH(WIDTH)) u_port_pin_state_gpio_sva (
	.sys_clk, .rst, .manual_rst, .hw_standby, .addr, .wdata, .wr, .rd, .rdata,
	.timer_mode_field, .io_control_b_field, .counter_clear_field, .timer2_out_b,
	.prescaler_select_ch0, .prescaler_select_ch5, .ch2_phase_count, .ch4_phase_count,
	.pin_out, .pin_oe, .timer2_capture_en, .ext_clock_d_en
);

// ---- test/port_pin_state_board.sv ----
// Board model that drives every pin the port leaves undriven.
module port_pin_state_board (
	// Pin side of the port
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe,
	output wire [7:0] pin_in,
	// Level the board applies to undriven pins
	input  wire [7:0] board_level
);
	timeunit 1ns;
	timeprecision 1ns;
	// A driven pin reads back its own level, so the board must never fight it.
	assign pin_in = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule // port_pin_state_board

// ---- test/tb_port_pin_state_gpio.sv ----
// Self-checking bench for the eight-bit port.
module tb_port_pin_state_gpio;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk = 0, rst = 1, manual_rst = 0, hw_standby = 0, sw_standby = 0;
	logic        wr = 0, rd = 0, pen = 0, pval = 0, tout = 0, ph2 = 0, ph4 = 0, e;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00, board = 8'h3C, dir = 8'h00, dat = 8'h00, pst;
	logic [7:0]  rdata, pin_in, pin_out, pin_oe;
	logic [3:0]  mode = 4'h2, iob = 4'h0;
	logic [1:0]  cclr = 2'h0;
	logic [2:0]  ps0 = 3'h0, ps5 = 3'h0;
	logic        cap_en, ext_en, io_b, clk_d;
	logic [10:0] tbl [9] = '{11'h009, 11'h020, 11'h048, 11'h000, 11'h2B9,
		11'h108, 11'h189, 11'h18C, 11'h1A0};
	int          n_mismatch = 0, checks = 0;
	port_pin_state_gpio u_port_pin_state_gpio (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
		.manual_rst(manual_rst), .hw_standby(hw_standby), .sw_standby(sw_standby),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.timer_mode_field(mode), .io_control_b_field(iob), .counter_clear_field(cclr),
		.timer2_out_b(tout), .prescaler_select_ch0(ps0), .prescaler_select_ch5(ps5),
		.ch2_phase_count(ph2), .ch4_phase_count(ph4), .pulse_out15_enable(pen),
		.pulse_output_15(pval), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.timer2_io_b(io_b), .timer2_capture_en(cap_en), .ext_clock_d(clk_d),
		.ext_clock_d_en(ext_en));
	port_pin_state_board u_port_pin_state_board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
		.board_level(board));
	// ==========================================================================
	// Helpers
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	function automatic logic [7:0] state();
		return (dat & dir) | (board & ~dir);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		chk(rdata, exp);
	endtask
	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// A hang is cut short here and counted as a mismatch.
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_mismatch++;
		summarize;
	end
	// ==========================================================================
	// Tests
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk(16'hFF60, 8'h00);
		rd_chk(16'hFEB0, 8'hFF);
		rd_chk(16'hFF00, 8'h00);
		rd_chk(16'hFF50, board);
		chk({6'h00, io_b, clk_d}, 8'h00);
		$display("test reset values done");
		dat = 8'hA5;
		dir = 8'h0F;
		wr_reg(16'hFF60, dat);
		wr_reg(16'hFEB0, dir);
		wr_reg(16'hFF50, 8'h5A);
		cyc(2);
		chk(pin_oe, dir);
		chk(pin_out, dat);
		rd_chk(16'hFF60, dat);
		rd_chk(16'hFF50, state());
		pst = state();
		@(posedge sys_clk);
		board <= 8'hC3;
		rd_chk(16'hFF50, pst);
		cyc(6);
		rd_chk(16'hFF50, state());
		$display("test registers and pins done");
		for (int i = 0; i < 9; i++) begin
			@(posedge sys_clk);
			{mode, iob, cclr, e} <= tbl[i];
			cyc(2);
			chk(pin_oe, {e, dir[6:0]});
			chk(pin_out, {e ? tout : dat[7], dat[6:0]});
		end
		@(posedge sys_clk);
		{mode, iob, ps0} <= {4'h0, 4'h8, 3'h7};
		cyc(2);
		chk({4'h0, io_b, clk_d, cap_en, ext_en}, 8'h0F);
		@(posedge sys_clk);
		{mode, ps0, ph2, ph4} <= {4'h2, 3'h0, 2'h3};
		cyc(2);
		chk({6'h00, cap_en, ext_en}, 8'h01);
		@(posedge sys_clk);
		ph4 <= 1'b0;
		cyc(2);
		chk({7'h00, ext_en}, 8'h00);
		@(posedge sys_clk);
		ps5 <= 3'h7;
		cyc(2);
		chk({7'h00, ext_en}, 8'h01);
		$display("test pin seven selection done");
		dir = 8'h8F;
		wr_reg(16'hFEB0, dir);
		@(posedge sys_clk);
		pen <= 1'b1;
		cyc(3);
		chk(pin_out, {pval, dat[6:0]});
		pst = state();
		@(posedge sys_clk);
		manual_rst <= 1'b1;
		board      <= ~board;
		cyc(8);
		chk(pin_out, dat);
		chk(pin_oe, dir);
		rd_chk(16'hFF50, pst);
		rd_chk(16'hFF60, dat);
		@(posedge sys_clk);
		manual_rst <= 1'b0;
		cyc(8);
		rd_chk(16'hFF50, state());
		$display("test manual reset done");
		pst = state();
		@(posedge sys_clk);
		sw_standby <= 1'b1;
		board      <= ~board;
		cyc(8);
		rd_chk(16'hFF50, pst);
		@(posedge sys_clk);
		sw_standby <= 1'b0;
		rd_chk(16'hFF60, dat);
		$display("test software standby done");
		@(posedge sys_clk);
		hw_standby <= 1'b1;
		cyc(2);
		@(posedge sys_clk);
		hw_standby <= 1'b0;
		cyc(2);
		chk(pin_oe, 8'h00);
		rd_chk(16'hFF60, 8'h00);
		cyc(6);
		rd_chk(16'hFF50, board);
		$display("test hardware standby done");
		summarize;
	end
endmodule // tb_port_pin_state_gpio
